//--- hw/abr_host_port.sv
// asynchronous byte-wide host port of a battery-backed rtc
// assumes all pin inputs are asynchronous and pass two flip-flops here;
// open-drain pins are given as pull-low enables, pad logic is outside

// Contract
// - accesses honoured only while select is low; otherwise strobes ignored
// - output enable gates whether data pins drive read data
// - time kept twice: internal counters and host-visible copy
// - host can suspend and resume copying into the visible copy
// - internal time advances while oscillator runs, regardless of copying
// - supply below trip level deselects, blocking reads and writes
// - during power fail external ram select forced inactive
// - alarm, watchdog or kickstart can raise interrupt; only watchdog can raise reset output
// - power request raised by wake input or wakeup alarm
// - software can release the power request
// - reset output held while supply is lost or failing
// - read mode when select and output enable low, write strobe high
// - data pins driven only with select and output enable active
// - read follows address changes with no new strobe edge
// - early enabled outputs may show intermediate data until access done
// - old data held briefly after address change, then new data
// - write mode when select and write strobe both low
// - write begins at the later falling edge of select or strobe
// - output enable low before write strobe may show read data
// - falling write strobe turns data drivers off within bounded delay
// - no host access accepted while reset output is asserted
// - reset held for a recovery period after supply returns
// - in retention host inputs ignored, data and interrupt outputs floated
module abr_host_port #(
	parameter int unsigned REC_CYCLES = abr_pkg::REC_CYCLES
) (
	input  wire logic       ref_clk_i,         // system clock
	input  wire logic       rst_i,             // async reset, high
	input  wire logic       select_n_i,        // device select pin
	input  wire logic       out_drive_n_i,     // output-drive enable pin
	input  wire logic       write_n_i,         // write strobe pin
	input  wire logic [4:0] addr_pins_i,       // address pins
	input  wire logic [7:0] data_pins_i,       // data pins, in
	output logic      [7:0] data_pins_o,       // data pins, out
	output logic            data_pins_oe_o,    // data pins drive
	input  wire logic       ext_ram_select_in_n_i,  // ram select in
	output logic            ext_ram_select_out_n_o, // ram select out
	input  wire logic       supply_fail_i,     // main supply below trip
	input  wire logic       kickstart_n_i,     // wake key input
	input  wire logic       osc_sec_i,         // 1 Hz oscillator level
	output logic            irq_n_oe_o,        // interrupt pull low
	output logic            reset_n_oe_o,      // reset pull low
	output logic            supply_on_request_n_oe_o // power request
);

	typedef struct packed {
		abr_pkg::abr_pins_t s1;
		abr_pkg::abr_pins_t s2;
		logic               osc_prev;
		logic               kick_prev;
		logic               tick_d;
		abr_pkg::abr_mode_t mode;
		logic [4:0]         wr_addr;
		logic [7:0]         wr_data;
		abr_pkg::abr_time_t vis;
		logic               pend;
		logic [7:0]         alarm_sec;
		logic [7:0]         wdog_reload;
		logic [7:0]         wdog_cnt;
		logic [7:0]         ctrl;
		logic [2:0]         flags;
		logic               pwr_req;
		logic [abr_pkg::REC_W-1:0] rec_cnt;
		logic [7:0]         dq;
		logic               dq_oe;
		logic               ram_out_n;
		logic               irq_oe;
		logic               rst_oe;
	} abr_st_t;

	// one counter serves power-up, supply fail and watchdog reset
	localparam logic [abr_pkg::REC_W-1:0] REC_LOAD =
		abr_pkg::REC_W'(REC_CYCLES);

	abr_st_t            r;
	abr_st_t            n;
	abr_pkg::abr_time_t tk_time;
	logic               tk_tick;
	logic               tk_load;

	assign tk_tick = r.s2.osc_sec & ~r.osc_prev
		& r.ctrl[abr_pkg::CTRL_OSC_RUN];
	assign tk_load = r.pend & r.ctrl[abr_pkg::CTRL_XFER_EN];

	abr_timekeeper u_tk (
		.ref_clk_i  (ref_clk_i),
		.rst_i      (rst_i),
		.tick_i     (tk_tick),
		.load_i     (tk_load),
		.load_val_i (r.vis),
		.time_o     (tk_time)
	);

	// time bytes sit at the bottom of the map
	function automatic logic is_time_addr(input logic [4:0] a);
		is_time_addr = (a <= abr_pkg::ADDR_CENTURY);
	endfunction

	// host-visible byte at an address; unmapped reads as zero
	function automatic logic [7:0] read_byte(input abr_st_t s,
		input logic [4:0] a);
		read_byte = 8'h00;
		if (is_time_addr(a))
			read_byte = s.vis[a[2:0]];
		else if (a == abr_pkg::ADDR_ALARM)
			read_byte = s.alarm_sec;
		else if (a == abr_pkg::ADDR_WDOG)
			read_byte = s.wdog_cnt;
		else if (a == abr_pkg::ADDR_CTRL)
			read_byte = s.ctrl;
		else if (a == abr_pkg::ADDR_FLAGS)
			read_byte = {5'h00, s.flags};
	endfunction

	always_comb begin
		abr_pkg::abr_pins_t p;
		logic       blocked;
		logic       commit;
		logic [7:0] rdata;
		logic [2:0] fset;
		logic [2:0] fclr;
		logic       wd_fire;
		logic       kick_fall;
		logic       alarm_hit;
		logic       pwr_set;
		logic       pwr_clr;
		p = r.s2;
		n = r;
		fset = 3'h0;
		fclr = 3'h0;
		blocked = 1'b0;
		commit = 1'b0;
		rdata = 8'h00;
		kick_fall = 1'b0;
		alarm_hit = 1'b0;
		pwr_set = 1'b0;
		pwr_clr = 1'b0;
		wd_fire = 1'b0;
		// two stages: pins move with no relation to this clock
		n.s1 = '{sel_n: select_n_i, oe_n: out_drive_n_i,
			we_n: write_n_i, addr: addr_pins_i, data: data_pins_i,
			ram_in_n: ext_ram_select_in_n_i, pfail: supply_fail_i,
			kick_n: kickstart_n_i, osc_sec: osc_sec_i};
		n.s2 = r.s1;
		n.osc_prev = p.osc_sec;
		n.kick_prev = p.kick_n;
		n.tick_d = tk_tick;

		// no access in fail or recovery
		blocked = p.pfail | (r.rec_cnt != '0);

		if (blocked || p.sel_n)
			n.mode = abr_pkg::MODE_DESEL;
		else if (!p.we_n)
			n.mode = abr_pkg::MODE_WRITE;
		else
			n.mode = abr_pkg::MODE_READ;

		if (n.mode == abr_pkg::MODE_WRITE) begin
			n.wr_addr = p.addr;
			n.wr_data = p.data;
		end
		// commit on first rise; a fail mid-write drops it
		commit = (r.mode == abr_pkg::MODE_WRITE)
			&& (n.mode != abr_pkg::MODE_WRITE) && !blocked;

		// copy internal time unless suspended or host data pending
		if (r.ctrl[abr_pkg::CTRL_XFER_EN]) begin
			if (r.pend)
				n.pend = 1'b0;
			else
				n.vis = tk_time;
		end

		// alarm compares seconds just after they advanced
		alarm_hit = r.tick_d && (tk_time[0] == r.alarm_sec);
		kick_fall = r.kick_prev & ~p.kick_n & ~p.pfail;

		// watchdog counts seconds down from its reload value
		if (r.ctrl[abr_pkg::CTRL_WDOG_EN] && tk_tick
			&& r.wdog_reload != 8'h00) begin
			if (r.wdog_cnt <= 8'h01) begin
				wd_fire = 1'b1;
				n.wdog_cnt = r.wdog_reload;
			end else begin
				n.wdog_cnt = r.wdog_cnt - 8'h01;
			end
		end

		if (commit) begin
			unique case (r.wr_addr)
				abr_pkg::ADDR_ALARM: n.alarm_sec = r.wr_data;
				abr_pkg::ADDR_WDOG: begin
					n.wdog_reload = r.wr_data;
					n.wdog_cnt = r.wr_data;
				end
				abr_pkg::ADDR_CTRL: begin
					n.ctrl = r.wr_data;
					n.ctrl[abr_pkg::CTRL_PWR_REL] = 1'b0;
					pwr_clr = r.wr_data[abr_pkg::CTRL_PWR_REL];
				end
				abr_pkg::ADDR_FLAGS: fclr = r.wr_data[2:0];
				default: begin
					// host writes land in the visible copy; pend then loads it into the counters
					if (is_time_addr(r.wr_addr)) begin
						n.vis[r.wr_addr[2:0]] = r.wr_data;
						n.pend = 1'b1;
					end
				end
			endcase
		end

		fset[abr_pkg::FLAG_ALARM] = alarm_hit;
		fset[abr_pkg::FLAG_WDOG] = wd_fire;
		fset[abr_pkg::FLAG_KICK] = kick_fall;
		n.flags = (r.flags & ~fclr) | fset;

		pwr_set = kick_fall
			| (alarm_hit & r.ctrl[abr_pkg::CTRL_WAKE_ALM]);
		if (pwr_set)
			n.pwr_req = 1'b1;
		else if (pwr_clr)
			n.pwr_req = 1'b0;

		// hold reset through fail plus recovery
		if (p.pfail)
			n.rec_cnt = REC_LOAD;
		// watchdog may reset the processor instead of interrupting
		else if (wd_fire && r.ctrl[abr_pkg::CTRL_WDOG_RST])
			n.rec_cnt = REC_LOAD;
		else if (r.rec_cnt != '0)
			n.rec_cnt = r.rec_cnt - 1'b1;

		// read data follows the synced address each cycle
		rdata = read_byte(r, p.addr);
		// bus may show stale data until the new byte lands
		n.dq = rdata;
		// drive only in read with enable low
		n.dq_oe = (n.mode == abr_pkg::MODE_READ) && !p.oe_n;

		// ram select forced off during fail
		n.ram_out_n = p.pfail | p.ram_in_n;
		n.irq_oe = !p.pfail && (
			(r.flags[abr_pkg::FLAG_ALARM]
				& r.ctrl[abr_pkg::CTRL_ALARM_IRQ])
			| (r.flags[abr_pkg::FLAG_KICK]
				& r.ctrl[abr_pkg::CTRL_KICK_IRQ])
			| (r.flags[abr_pkg::FLAG_WDOG]
				& r.ctrl[abr_pkg::CTRL_WDOG_EN]
				& ~r.ctrl[abr_pkg::CTRL_WDOG_RST]));
		n.rst_oe = p.pfail | (r.rec_cnt != '0);
	end

	// power-up counts as a fail: reset stays low for the recovery time
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '0;
			r.s1 <= abr_pkg::PINS_IDLE;
			r.s2 <= abr_pkg::PINS_IDLE;
			r.osc_prev <= 1'b0;
			r.kick_prev <= 1'b1;
			r.mode <= abr_pkg::MODE_DESEL;
			r.ctrl <= abr_pkg::CTRL_RST;
			r.rec_cnt <= REC_LOAD;
			r.ram_out_n <= 1'b1;
			r.rst_oe <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign data_pins_o = r.dq;
	assign data_pins_oe_o = r.dq_oe;
	assign ext_ram_select_out_n_o = r.ram_out_n;
	assign irq_n_oe_o = r.irq_oe;
	assign reset_n_oe_o = r.rst_oe;
	assign supply_on_request_n_oe_o = r.pwr_req;

endmodule

//--- hw/abr_pkg.sv
// shared constants and carrier types for the byte-wide rtc host port
// assumes one 125 MHz clock; all pin levels arrive unsynchronised
package abr_pkg;

	localparam int unsigned CLK_MHZ = 125;
	// reset_recovery_period in microseconds
	localparam int unsigned REC_TIME_US = 200;
	localparam int unsigned REC_CYCLES = REC_TIME_US * CLK_MHZ;
	localparam int unsigned REC_W = 24;

	// host-visible locations
	localparam logic [4:0] ADDR_SEC     = 5'h00;
	localparam logic [4:0] ADDR_CENTURY = 5'h07;
	localparam logic [4:0] ADDR_ALARM   = 5'h08;
	localparam logic [4:0] ADDR_WDOG    = 5'h09;
	localparam logic [4:0] ADDR_CTRL    = 5'h0a;
	localparam logic [4:0] ADDR_FLAGS   = 5'h0b;

	// control register fields
	localparam int unsigned CTRL_XFER_EN   = 0;
	localparam int unsigned CTRL_OSC_RUN   = 1;
	localparam int unsigned CTRL_ALARM_IRQ = 2;
	localparam int unsigned CTRL_WDOG_EN   = 3;
	localparam int unsigned CTRL_WDOG_RST  = 4;
	localparam int unsigned CTRL_KICK_IRQ  = 5;
	localparam int unsigned CTRL_WAKE_ALM  = 6;
	localparam int unsigned CTRL_PWR_REL   = 7;
	localparam logic [7:0]  CTRL_RST       = 8'h03;

	// flag register fields
	localparam int unsigned FLAG_ALARM = 0;
	localparam int unsigned FLAG_WDOG  = 1;
	localparam int unsigned FLAG_KICK  = 2;

	// counting limits of the internal time bytes
	localparam logic [7:0] SEC_MAX  = 8'h3b;
	localparam logic [7:0] MIN_MAX  = 8'h3b;
	localparam logic [7:0] HOUR_MAX = 8'h17;
	localparam logic [7:0] DAY_MIN  = 8'h01;
	localparam logic [7:0] DAY_MAX  = 8'h07;

	typedef logic [7:0][7:0] abr_time_t;

	typedef enum logic [1:0] {
		MODE_DESEL = 2'h0,
		MODE_READ  = 2'h1,
		MODE_WRITE = 2'h2
	} abr_mode_t;

	typedef struct packed {
		logic       sel_n;
		logic       oe_n;
		logic       we_n;
		logic [4:0] addr;
		logic [7:0] data;
		logic       ram_in_n;
		logic       pfail;
		logic       kick_n;
		logic       osc_sec;
	} abr_pins_t;

	localparam abr_pins_t PINS_IDLE = '{
		sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 5'h00, data: 8'h00,
		ram_in_n: 1'b1, pfail: 1'b1, kick_n: 1'b1, osc_sec: 1'b0};

endpackage

//--- hw/abr_timekeeper.sv
// internal counting copy of the time registers
// assumes tick_i is a one-cycle pulse once per second, same clock
module abr_timekeeper (
	input  wire logic              ref_clk_i,  // system clock
	input  wire logic              rst_i,      // async reset, high
	input  wire logic              tick_i,     // one-second pulse
	input  wire logic              load_i,     // take load_val_i
	input  wire abr_pkg::abr_time_t load_val_i, // host-written time
	output abr_pkg::abr_time_t      time_o      // internal time
);

	typedef struct packed {
		abr_pkg::abr_time_t t;
	} abr_tk_st_t;

	abr_tk_st_t r;
	abr_tk_st_t n;

	// returns {carry, next value}
	function automatic logic [8:0] inc_wrap(input logic [7:0] v,
		input logic [7:0] lo, input logic [7:0] hi);
		if (v >= hi)
			inc_wrap = {1'b1, lo};
		else
			inc_wrap = {1'b0, 8'(v + 8'h01)};
	endfunction

	always_comb begin
		logic [8:0] s;
		logic [8:0] m;
		logic [8:0] h;
		logic [8:0] d;
		s = inc_wrap(r.t[0], 8'h00, abr_pkg::SEC_MAX);
		m = inc_wrap(r.t[1], 8'h00, abr_pkg::MIN_MAX);
		h = inc_wrap(r.t[2], 8'h00, abr_pkg::HOUR_MAX);
		d = inc_wrap(r.t[3], abr_pkg::DAY_MIN, abr_pkg::DAY_MAX);
		n = r;
		if (load_i) begin
			n.t = load_val_i;
		end else if (tick_i) begin
			n.t[0] = s[7:0];
			if (s[8]) begin
				n.t[1] = m[7:0];
				if (m[8]) begin
					n.t[2] = h[7:0];
					if (h[8])
						n.t[3] = d[7:0];
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			r <= '0;
		else
			r <= n;
	end

	assign time_o = r.t;

endmodule

//--- verification/abr_host_port_properties.sv
// pin-level assertions for the byte-wide rtc host port
// assumes 3-edge pin-to-output latency; bound to every abr_host_port
module abr_host_port_properties #(
	parameter int unsigned REC_CYCLES = 20
) (
	input wire logic ref_clk_i,              // clock
	input wire logic rst_i,                  // async reset
	input wire logic select_n_i,             // select pin
	input wire logic out_drive_n_i,          // output enable pin
	input wire logic write_n_i,              // write strobe
	input wire logic data_pins_oe_o,         // data drive
	input wire logic ext_ram_select_in_n_i,  // ram select in
	input wire logic ext_ram_select_out_n_o, // ram select out
	input wire logic supply_fail_i,          // supply low
	input wire logic reset_n_oe_o            // reset pull low
);
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	// cycles of reset held with good supply
	logic [15:0] rec_cnt_r;
	logic [15:0] rec_cnt_nxt;
	always_comb begin
		rec_cnt_nxt = rec_cnt_r;
		if (supply_fail_i || !reset_n_oe_o)
			rec_cnt_nxt = 16'h0000;
		else if (rec_cnt_r != 16'hffff)
			rec_cnt_nxt = rec_cnt_r + 16'h0001;
	end
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			rec_cnt_r <= 16'h0000;
		else
			rec_cnt_r <= rec_cnt_nxt;
	end

	sequence s_rd_held;
		(!select_n_i && !out_drive_n_i && write_n_i && !supply_fail_i
			&& !reset_n_oe_o)[*4];
	endsequence
	sequence s_fail_held;
		supply_fail_i[*2];
	endsequence

	property p_rd_drive;
		s_rd_held |=> data_pins_oe_o;
	endproperty
	property p_drive_cause;
		data_pins_oe_o |-> $past(!select_n_i, 3) && $past(!out_drive_n_i, 3);
	endproperty
	property p_strobe_float;
		!write_n_i |-> ##3 !data_pins_oe_o;
	endproperty
	property p_fail_float;
		supply_fail_i |-> ##3 !data_pins_oe_o;
	endproperty
	property p_ram_forced;
		supply_fail_i |-> ##3 ext_ram_select_out_n_o;
	endproperty
	property p_ram_pass;
		!supply_fail_i && !ext_ram_select_in_n_i |-> ##3 !ext_ram_select_out_n_o;
	endproperty
	property p_rst_on_fail;
		s_fail_held |-> ##[2:3] reset_n_oe_o;
	endproperty
	property p_no_access_rst;
		reset_n_oe_o[*2] |-> !data_pins_oe_o;
	endproperty
	property p_rec_min;
		$fell(reset_n_oe_o) |-> rec_cnt_r + 16'h0001 >= REC_CYCLES;
	endproperty
	property p_rec_max;
		rec_cnt_r <= REC_CYCLES + 8;
	endproperty

	a_rd_drive: assert property (p_rd_drive)
		else $error("read mode without data drive");
	a_drive_cause: assert property (p_drive_cause)
		else $error("data driven without select and enable");
	a_strobe_float: assert property (p_strobe_float)
		else $error("data still driven under write strobe");
	a_fail_float: assert property (p_fail_float)
		else $error("data driven during power fail");
	a_ram_forced: assert property (p_ram_forced)
		else $error("ram select not forced off in fail");
	a_ram_pass: assert property (p_ram_pass)
		else $error("ram select not passed through");
	a_rst_on_fail: assert property (p_rst_on_fail)
		else $error("reset not held during fail");
	a_no_access_rst: assert property (p_no_access_rst)
		else $error("access while reset held");
	a_rec_min: assert property (p_rec_min)
		else $error("reset released too early");
	a_rec_max: assert property (p_rec_max)
		else $error("reset held too long");
endmodule

bind abr_host_port abr_host_port_properties #(
	.REC_CYCLES(REC_CYCLES)
) u_props (
	.ref_clk_i, .rst_i, .select_n_i, .out_drive_n_i, .write_n_i,
	.data_pins_oe_o, .ext_ram_select_in_n_i, .ext_ram_select_out_n_o,
	.supply_fail_i, .reset_n_oe_o
);

//--- verification/abr_bus_master.sv
// behavioural bus master on the far side of the host port
// assumes strobes change 1 ns after a rising edge; pins are synced inside
module abr_bus_master (
	input  wire logic       ref_clk_i, // clock
	input  wire logic [7:0] bus_i,     // resolved data pins
	output logic            sel_n_o,   // select
	output logic            oe_n_o,    // output enable
	output logic            we_n_o,    // write strobe
	output logic      [4:0] addr_o,    // address
	output logic      [7:0] dq_o,      // write data
	output logic            drv_o      // master drives data
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		sel_n_o = 1'b1;
		oe_n_o = 1'b1;
		we_n_o = 1'b1;
		addr_o = 5'h00;
		dq_o = 8'h00;
		drv_o = 1'b0;
	end

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	// strobes high long enough to be seen
	task automatic idle();
		sel_n_o = 1'b1;
		oe_n_o = 1'b1;
		we_n_o = 1'b1;
		drv_o = 1'b0;
		step(4);
	endtask

	// last=0 keeps the read open so the next address ripples
	task automatic rd(input logic [4:0] a, input bit last,
			output logic [7:0] d);
		sel_n_o = 1'b0;
		oe_n_o = 1'b0;
		addr_o = a;
		step(5);
		d = bus_i;
		if (last)
			idle();
	endtask

	// address and data held through the write
	task automatic wr(input logic [4:0] a, input logic [7:0] v,
			input bit oe, input bit sel);
		sel_n_o = !sel;
		oe_n_o = !oe;
		addr_o = a;
		step(4);
		we_n_o = 1'b0;
		dq_o = v;
		drv_o = 1'b1;
		step(4);
		we_n_o = 1'b1;
		step(1);
		idle();
	endtask
endmodule

//--- verification/abr_host_port_tb.sv
// self-checking bench for the byte-wide rtc host port
// assumes abr_bus_master as far side and the bound property checker
module abr_host_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned REC = 20;
	typedef struct packed {
		logic [4:0] a;
		logic [7:0] w;
		logic [7:0] e;
	} abr_row_t;
	logic       ref_clk_i, rst_i, select_n_i, out_drive_n_i, write_n_i;
	logic [4:0] addr_pins_i;
	logic [7:0] data_pins_o, mdq, rd_v, bus;
	logic [7:0] last_bus = 8'h00;
	logic       data_pins_oe_o, ext_ram_select_in_n_i, ext_ram_select_out_n_o;
	logic       supply_fail_i, kickstart_n_i, osc_sec_i, mdrv;
	logic       irq_n_oe_o, reset_n_oe_o, supply_on_request_n_oe_o;
	int         n_errors = 0;
	int         n_compared = 0;
	int         cycles = 0;
	int         n;
	abr_row_t   rows [7] = '{'{5'h08, 8'h2a, 8'h2a}, '{5'h00, 8'h15, 8'h15},
		'{5'h02, 8'h17, 8'h17}, '{5'h07, 8'h55, 8'h55},
		'{5'h0a, 8'h83, 8'h03}, '{5'h0c, 8'h5a, 8'h00}, '{5'h1f, 8'ha5, 8'h00}};

	// released bus shows no stale value
	assign bus = data_pins_oe_o ? data_pins_o : mdrv ? mdq : ~last_bus;
	always @(posedge ref_clk_i)
		last_bus <= bus;

	abr_host_port #(.REC_CYCLES(REC)) dut (
		.ref_clk_i, .rst_i, .select_n_i, .out_drive_n_i, .write_n_i,
		.addr_pins_i, .data_pins_i(bus), .data_pins_o, .data_pins_oe_o,
		.ext_ram_select_in_n_i, .ext_ram_select_out_n_o, .supply_fail_i,
		.kickstart_n_i, .osc_sec_i, .irq_n_oe_o, .reset_n_oe_o,
		.supply_on_request_n_oe_o);
	abr_bus_master m (.ref_clk_i, .bus_i(bus), .sel_n_o(select_n_i),
		.oe_n_o(out_drive_n_i), .we_n_o(write_n_i), .addr_o(addr_pins_i),
		.dq_o(mdq), .drv_o(mdrv));

	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end

	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic report_and_stop();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic rst_vals();
		chk1(reset_n_oe_o, 1'b1);
		chk1(data_pins_oe_o, 1'b0);
		chk1(ext_ram_select_out_n_o, 1'b1);
		chk1(irq_n_oe_o, 1'b0);
		chk1(supply_on_request_n_oe_o, 1'b0);
	endtask
	task automatic wait_rec();
		n = 0;
		while (reset_n_oe_o === 1'b1 && n < 200) begin
			m.step(1);
			n++;
		end
		chk1(n >= REC && n <= REC + 8, 1'b1);
	endtask
	task automatic tick();
		osc_sec_i = 1'b1;
		m.step(4);
		osc_sec_i = 1'b0;
		m.step(4);
	endtask

	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 4000) begin
			n_errors++;
			report_and_stop();
		end
	end

	initial begin
		rst_i = 1'b1;
		supply_fail_i = 1'b0;
		kickstart_n_i = 1'b1;
		osc_sec_i = 1'b0;
		ext_ram_select_in_n_i = 1'b0;
		repeat (10) @(posedge ref_clk_i);
		#1 rst_i = 1'b0;
		wait_rec();
		foreach (rows[i]) begin
			m.wr(rows[i].a, rows[i].w, 1'b0, 1'b1);
			m.rd(rows[i].a, 1'b1, rd_v);
			chk8(rd_v, rows[i].e);
		end
		m.rd(5'h08, 1'b0, rd_v);
		m.rd(5'h02, 1'b1, rd_v);
		chk8(rd_v, 8'h17);
		m.wr(5'h08, 8'h3c, 1'b1, 1'b1);
		m.rd(5'h08, 1'b1, rd_v);
		chk8(rd_v, 8'h3c);
		m.wr(5'h08, 8'h99, 1'b0, 1'b0);
		m.rd(5'h08, 1'b1, rd_v);
		chk8(rd_v, 8'h3c);
		supply_fail_i = 1'b1;
		m.step(4);
		chk1(ext_ram_select_out_n_o, 1'b1);
		chk1(reset_n_oe_o, 1'b1);
		m.wr(5'h08, 8'h77, 1'b0, 1'b1);
		supply_fail_i = 1'b0;
		wait_rec();
		chk1(ext_ram_select_out_n_o, 1'b0);
		ext_ram_select_in_n_i = 1'b1;
		m.step(4);
		chk1(ext_ram_select_out_n_o, 1'b1);
		ext_ram_select_in_n_i = 1'b0;
		m.step(4);
		chk1(ext_ram_select_out_n_o, 1'b0);
		m.rd(5'h08, 1'b1, rd_v);
		chk8(rd_v, 8'h3c);
		m.wr(5'h00, 8'h00, 1'b0, 1'b1);
		m.wr(5'h0a, 8'h02, 1'b0, 1'b1);
		tick();
		tick();
		m.rd(5'h00, 1'b1, rd_v);
		chk8(rd_v, 8'h00);
		m.wr(5'h0a, 8'h03, 1'b0, 1'b1);
		m.rd(5'h00, 1'b1, rd_v);
		chk8(rd_v, 8'h02);
		m.wr(5'h0a, 8'h23, 1'b0, 1'b1);
		kickstart_n_i = 1'b0;
		m.step(4);
		kickstart_n_i = 1'b1;
		m.step(2);
		chk1(supply_on_request_n_oe_o, 1'b1);
		chk1(irq_n_oe_o, 1'b1);
		m.wr(5'h0b, 8'h04, 1'b0, 1'b1);
		chk1(irq_n_oe_o, 1'b0);
		m.wr(5'h0a, 8'ha3, 1'b0, 1'b1);
		chk1(supply_on_request_n_oe_o, 1'b0);
		m.wr(5'h08, 8'h03, 1'b0, 1'b1);
		m.wr(5'h0a, 8'h47, 1'b0, 1'b1);
		tick();
		chk1(irq_n_oe_o, 1'b1);
		chk1(supply_on_request_n_oe_o, 1'b1);
		m.wr(5'h09, 8'h01, 1'b0, 1'b1);
		m.wr(5'h0a, 8'h1b, 1'b0, 1'b1);
		tick();
		chk1(reset_n_oe_o, 1'b1);
		rst_i = 1'b1;
		m.step(2);
		rst_vals();
		rst_i = 1'b0;
		wait_rec();
		m.rd(5'h0a, 1'b1, rd_v);
		chk8(rd_v, 8'h03);
		report_and_stop();
	end
endmodule
